// File: rtl/rdv_defines.svh
// Offsets, field positions, reset values and timing counts of the ring detector
`ifndef RDV_DEFINES_SVH
`define RDV_DEFINES_SVH
`define RDV_CTRL_OFS 4'h0
`define RDV_VALID_OFS 4'h4
`define RDV_STAT_OFS 4'h8
`define RDV_CTRL_W 11
`define RDV_VALID_W 22
`define RDV_CTRL_RST 11'h000
`define RDV_VALID_RST 22'h0A22A8
`define RDV_STAT_IRQ_BIT 3
`define RDV_RESP_OK 2'h0
`define RDV_RESP_ERR 2'h2
`define RDV_CLK_NS 10
`define RDV_TICK_NS 1000000
`define RDV_TICK_CYC (`RDV_TICK_NS / `RDV_CLK_NS)
`define RDV_SAMPLE_NS 125000
`define RDV_SAMPLE_CYC (`RDV_SAMPLE_NS / `RDV_CLK_NS)
`define RDV_ONESHOT_MS 5000
`define RDV_DUR_UNIT_MS 128
`define RDV_END_UNIT_MS 128
`define RDV_DLY_UNIT_MS 256
`define RDV_TX_HIGH 16'h7FFF
`define RDV_TX_LOW 16'h8000
`define RDV_TX_MID 16'h04CC
`define RDV_TX_IDLE 16'h0000
`endif

// File: rtl/rdv_pkg.sv
// Types shared by the ring detector design
package rdv_pkg;
  typedef enum logic [1:0] {VS_IDLE, VS_FREQ, VS_ENV} rdv_vstate_type;
  typedef struct packed {
    logic ring_irq_mask;
    logic irq_active_high;
    logic isolation_link_powerdown;
    logic validation_enable;
    logic onhook_monitor;
    logic off_hook;
    logic threshold_sel_hi;
    logic full_wave_sel;
    logic both_edge_irq_sel;
    logic ring_out_polarity;
    logic threshold_sel_lo;
  } rdv_ctrl_type;
  typedef struct packed {
    logic [2:0] valid_indicate_delay;
    logic [3:0] ring_end_timeout;
    logic [2:0] valid_duration_count;
    logic [5:0] freq_high_limit_count;
    logic [5:0] freq_low_timeout;
  } rdv_valid_type;
endpackage

// File: rtl/rdv_top.sv
// Ring detector with validation, status, interrupt and sample coding
// Behaviour
// - Half-wave mode detects positive excursions only
// - Full-wave mode detects both polarities
// - Indicator pin active low unless polarity set
// - Indicator follows detected excursions per mode
// - Positive and negative flags follow comparators
// - Detect flag is retriggerable five second one-shot
// - Off-hook clears detect flag at once
// - Masked interrupt pin; software clears flag
// - Edge select picks rising or both edges
// - Ring samples only when link up, idle
// - Half-wave samples 0x8000 or 0x7FFF
// - Full-wave samples mid, high or low
// - Alternating crossing interval within both limits
// - Duration validates, then end timeout watches
// - Delay timer must beat ring end
// - Validation enable; sleep needs PCM clock
// - Validated envelope drives detect flag
// - Detect flag edges raise interrupt, envelope or one-shot
// - Indicator: envelope half-wave, one-shot full-wave
// - Two select bits choose threshold level
`timescale 1ns/100ps
`include "rdv_defines.svh"
module rdv_top #(
  parameter int TICK_CYC   = `RDV_TICK_CYC,   // Cycles per 1 ms tick
  parameter int SAMPLE_CYC = `RDV_SAMPLE_CYC, // Cycles per sample
  parameter int ONESHOT_MS = `RDV_ONESHOT_MS  // One-shot length in ticks
) (
  input  wire logic        aclk,                  // Clock
  input  wire logic        aresetn,               // Sync reset, low
  input  wire logic [3:0]  awaddr,                // Write address
  input  wire logic        awvalid,               // Write address valid
  output logic             awready,               // Write address ready
  input  wire logic [31:0] wdata,                 // Write data
  input  wire logic [3:0]  wstrb,                 // Byte enables
  input  wire logic        wvalid,                // Write data valid
  output logic             wready,                // Write data ready
  output logic [1:0]       bresp,                 // Write response
  output logic             bvalid,                // Write response valid
  input  wire logic        bready,                // Write response ready
  input  wire logic [3:0]  araddr,                // Read address
  input  wire logic        arvalid,               // Read address valid
  output logic             arready,               // Read address ready
  output logic [31:0]      rdata,                 // Read data
  output logic [1:0]       rresp,                 // Read response
  output logic             rvalid,                // Read data valid
  input  wire logic        rready,                // Read data ready
  input  wire logic        ring_sense_a,          // Above positive threshold
  input  wire logic        ring_sense_b,          // Below negative threshold
  input  wire logic        sleep_mode,            // Low-power sleep
  input  wire logic        pcm_clock_ok,          // External PCM clock valid
  output logic [1:0]       threshold_sel,         // {hi, lo} to comparators
  output logic             ring_indicator_pin_o,  // Open-drain data, always 0
  output logic             ring_indicator_pin_oe, // Pulls pin low when high
  output logic             analog_out_irq_pin,    // Interrupt pin
  output logic [15:0]      transmit_sample_out,   // Coded ring sample
  output logic             transmit_sample_valid  // New sample pulse
);
  import rdv_pkg::*;

  if (TICK_CYC < 1 || SAMPLE_CYC < 1 || ONESHOT_MS < 1 || ONESHOT_MS > 8191) begin : g_chk
    $error("rdv_top: parameter out of range");
  end

  rdv_ctrl_type   ctrl;
  rdv_valid_type  vcfg;
  rdv_vstate_type vstate;
  logic [3:0]  sync_s1;
  logic [3:0]  sync_s2;
  logic        pos_q;
  logic        neg_q;
  logic [31:0] tick_cnt;
  logic        tick;
  logic [31:0] smp_cnt;
  logic        smp_tick;
  logic [12:0] os_cnt;
  logic        rdf;
  logic        rdf_q;
  logic        irq_flag;
  logic        env;
  logic        last_pos;
  logic [6:0]  ivl_cnt;
  logic [10:0] dur_cnt;
  logic [10:0] end_cnt;
  logic        dly_run;
  logic [10:0] dly_cnt;
  logic        aw_hold;
  logic        w_hold;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  logic pos;
  logic neg;
  logic pos_rise;
  logic neg_rise;
  logic trig;
  logic alt;
  logic in_tol;
  logic val_on;
  logic oneshot;
  logic ind_active;
  logic irq_evt;
  logic irq_clr;
  logic commit;
  logic [31:0] wmask;

  // Comparator and pin inputs, two stages before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_s1 <= 4'h0;
      sync_s2 <= 4'h0;
    end else begin
      sync_s1 <= {pcm_clock_ok, sleep_mode, ring_sense_b, ring_sense_a};
      sync_s2 <= sync_s1;
    end
  end

  assign pos      = sync_s2[0];
  assign neg      = sync_s2[1];
  assign val_on   = ctrl.validation_enable && (!sync_s2[2] || sync_s2[3]);
  assign pos_rise = pos && !pos_q;
  assign neg_rise = neg && !neg_q;
  assign trig     = pos_rise || (ctrl.full_wave_sel && neg_rise);
  assign alt      = (pos_rise && !last_pos) || (neg_rise && last_pos);
  assign in_tol   = ivl_cnt <= {1'b0, vcfg.freq_low_timeout} &&
                    ivl_cnt >= {1'b0, vcfg.freq_high_limit_count};
  assign oneshot  = os_cnt != 13'h0000;

  // Crossing edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      pos_q <= pos;
      neg_q <= neg;
    end
  end

  // Millisecond and sample dividers; all timers count ms ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= tick_cnt == 32'(TICK_CYC - 1);
      tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_cnt  <= 32'h0;
      smp_tick <= 1'b0;
    end else begin
      smp_tick <= smp_cnt == 32'(SAMPLE_CYC - 1);
      smp_cnt  <= (smp_cnt == 32'(SAMPLE_CYC - 1)) ? 32'h0 : smp_cnt + 32'h1;
    end
  end

  // Retriggerable one-shot; off-hook empties it at once
  always_ff @(posedge aclk) begin
    if (!aresetn || ctrl.off_hook) begin
      os_cnt <= 13'h0000;
    end else if (trig) begin
      os_cnt <= 13'(ONESHOT_MS);
    end else if (tick && oneshot) begin
      os_cnt <= os_cnt - 13'h0001;
    end
  end

  // Validation engine: frequency check, then end-of-ring watch
  always_ff @(posedge aclk) begin
    if (!aresetn || !val_on || ctrl.off_hook) begin
      vstate   <= VS_IDLE;
      env      <= 1'b0;
      last_pos <= 1'b0;
      ivl_cnt  <= 7'h00;
      dur_cnt  <= 11'h000;
      end_cnt  <= 11'h000;
      dly_run  <= 1'b0;
      dly_cnt  <= 11'h000;
    end else begin
      if (pos_rise || neg_rise) begin
        last_pos <= pos_rise;
      end
      // Interval since last alternating crossing, saturating
      if (alt) begin
        ivl_cnt <= 7'h00;
      end else if (tick && ivl_cnt != 7'h7F) begin
        ivl_cnt <= ivl_cnt + 7'h01;
      end
      if (pos_rise || neg_rise) begin
        end_cnt <= 11'h000;
      end else if (tick && end_cnt != 11'h7FF) begin
        end_cnt <= end_cnt + 11'h001;
      end
      // Delay runs from first good interval, through the end watch
      if (dly_run && tick && dly_cnt != 11'h7FF) begin
        dly_cnt <= dly_cnt + 11'h001;
      end
      if (dly_run && dly_cnt >= 11'(vcfg.valid_indicate_delay * `RDV_DLY_UNIT_MS)) begin
        env <= 1'b1;
      end
      case (vstate)
        VS_IDLE: begin
          if (pos_rise || neg_rise) begin
            vstate <= VS_FREQ;
          end
        end
        VS_FREQ: begin
          if (dly_run && tick && dur_cnt != 11'h7FF) begin
            dur_cnt <= dur_cnt + 11'h001;
          end
          if ((alt && !in_tol) || ivl_cnt > {1'b0, vcfg.freq_low_timeout}) begin
            vstate  <= VS_IDLE;
            env     <= 1'b0;
            dly_run <= 1'b0;
            dly_cnt <= 11'h000;
            dur_cnt <= 11'h000;
          end else begin
            if (alt && !dly_run) begin
              dly_run <= 1'b1;
            end
            if (dly_run && dur_cnt >= 11'(vcfg.valid_duration_count * `RDV_DUR_UNIT_MS)) begin
              vstate <= VS_ENV;
            end
          end
        end
        VS_ENV: begin
          // Ring end before the delay ran out leaves env low
          if (end_cnt >= 11'(vcfg.ring_end_timeout * `RDV_END_UNIT_MS)) begin
            vstate  <= VS_IDLE;
            env     <= 1'b0;
            dly_run <= 1'b0;
            dly_cnt <= 11'h000;
            dur_cnt <= 11'h000;
          end
        end
        default: begin
          vstate <= VS_IDLE;
        end
      endcase
    end
  end

  // Detect flag: envelope when validating, else the one-shot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdf   <= 1'b0;
      rdf_q <= 1'b0;
    end else begin
      rdf   <= !ctrl.off_hook && (val_on ? env : oneshot);
      rdf_q <= rdf;
    end
  end

  assign irq_evt = (rdf && !rdf_q) || (ctrl.both_edge_irq_sel && !rdf && rdf_q);
  assign irq_clr = commit && aw_addr == `RDV_STAT_OFS && w_strb[0] && w_data[`RDV_STAT_IRQ_BIT];

  // Interrupt flag: a new event wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag <= 1'b0;
    end else if (irq_evt) begin
      irq_flag <= 1'b1;
    end else if (irq_clr) begin
      irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_out_irq_pin <= 1'b1;
    end else begin
      analog_out_irq_pin <= (ctrl.ring_irq_mask && irq_flag) == ctrl.irq_active_high;
    end
  end

  // Indicator source by mode; open drain can only pull low
  always_comb begin
    if (val_on) begin
      ind_active = ctrl.full_wave_sel ? oneshot : env;
    end else begin
      ind_active = ctrl.full_wave_sel ? (pos || neg) : pos;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_indicator_pin_o  <= 1'b0;
      ring_indicator_pin_oe <= 1'b0;
      threshold_sel         <= 2'h0;
    end else begin
      ring_indicator_pin_o  <= 1'b0;
      ring_indicator_pin_oe <= ctrl.ring_out_polarity ? !ind_active : ind_active;
      threshold_sel         <= {ctrl.threshold_sel_hi, ctrl.threshold_sel_lo};
    end
  end

  // Sample coding at the sample rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_sample_out   <= `RDV_TX_IDLE;
      transmit_sample_valid <= 1'b0;
    end else begin
      transmit_sample_valid <= smp_tick;
      if (smp_tick) begin
        if (ctrl.isolation_link_powerdown || ctrl.off_hook || ctrl.onhook_monitor) begin
          transmit_sample_out <= `RDV_TX_IDLE;
        end else if (pos) begin
          transmit_sample_out <= `RDV_TX_HIGH;
        end else if (neg || !ctrl.full_wave_sel) begin
          transmit_sample_out <= `RDV_TX_LOW;
        end else begin
          transmit_sample_out <= `RDV_TX_MID;
        end
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign commit = aw_hold && w_hold && !bvalid;
  assign wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RDV_RESP_OK;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (commit) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (aw_addr == `RDV_CTRL_OFS || aw_addr == `RDV_VALID_OFS ||
                    aw_addr == `RDV_STAT_OFS) ? `RDV_RESP_OK : `RDV_RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Control and validation registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `RDV_CTRL_RST;
      vcfg <= `RDV_VALID_RST;
    end else if (commit && aw_addr == `RDV_CTRL_OFS) begin
      ctrl <= (ctrl & ~wmask[`RDV_CTRL_W-1:0]) | (w_data[`RDV_CTRL_W-1:0] & wmask[`RDV_CTRL_W-1:0]);
    end else if (commit && aw_addr == `RDV_VALID_OFS) begin
      vcfg <= (vcfg & ~wmask[`RDV_VALID_W-1:0]) | (w_data[`RDV_VALID_W-1:0] & wmask[`RDV_VALID_W-1:0]);
    end
  end

  // AXI4-Lite read, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RDV_RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RDV_RESP_OK;
      case (araddr)
        `RDV_CTRL_OFS:  rdata <= {21'h0, ctrl};
        `RDV_VALID_OFS: rdata <= {10'h0, vcfg};
        `RDV_STAT_OFS:  rdata <= {28'h0, irq_flag, rdf, neg, pos};
        default: begin
          rdata <= 32'h0;
          rresp <= `RDV_RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rise_irq_a: assert property ($rose(rdf) |=> irq_flag)
    else $error("rising detect did not set interrupt");
  fall_irq_a: assert property (ctrl.both_edge_irq_sel && $fell(rdf) |=> irq_flag)
    else $error("falling detect did not set interrupt");
  offhook_clear_a: assert property (ctrl.off_hook |=> !rdf ##1 !rdf)
    else $error("off-hook left detect flag set");
  half_ind_a: assert property (!val_on && !ctrl.full_wave_sel && neg && !pos
    |=> ring_indicator_pin_oe == $past(ctrl.ring_out_polarity))
    else $error("half-wave indicator reacted to negative");
  full_ind_a: assert property (!val_on && ctrl.full_wave_sel && neg
    |=> ring_indicator_pin_oe != $past(ctrl.ring_out_polarity))
    else $error("full-wave indicator missed negative");
  tx_half_a: assert property (smp_tick && !ctrl.full_wave_sel && !pos && !ctrl.isolation_link_powerdown
    && !ctrl.off_hook && !ctrl.onhook_monitor |=> transmit_sample_out == `RDV_TX_LOW)
    else $error("half-wave rest sample wrong");
  tx_full_a: assert property (smp_tick && ctrl.full_wave_sel && !pos && !neg && !ctrl.isolation_link_powerdown
    && !ctrl.off_hook && !ctrl.onhook_monitor |=> transmit_sample_out == `RDV_TX_MID)
    else $error("full-wave rest sample wrong");
  tx_gate_a: assert property (smp_tick && ctrl.isolation_link_powerdown
    |=> transmit_sample_out == `RDV_TX_IDLE)
    else $error("ring data sent with link down");
  oneshot_load_a: assert property (trig && !ctrl.off_hook |=> os_cnt == 13'(ONESHOT_MS))
    else $error("one-shot not restarted");
  env_delay_a: assert property ($rose(env) |-> $past(dly_run))
    else $error("envelope without delay timer");
  val_off_a: assert property (!val_on |=> vstate == VS_IDLE && !env)
    else $error("validation active while disabled");
  irq_pin_a: assert property (ctrl.ring_irq_mask && irq_flag && !ctrl.irq_active_high
    |=> !analog_out_irq_pin)
    else $error("interrupt pin not asserted");

  valid_ring_c: cover property (val_on && $rose(rdf));
  env_watch_c: cover property (vstate == VS_ENV ##1 vstate == VS_IDLE);
  fall_irq_c: cover property (ctrl.both_edge_irq_sel && $fell(rdf));
endmodule

// File: bench/rdv_line_model.sv
// Line-side comparator and indicator pull-up model
`timescale 1ns/100ps
module rdv_line_model (
  input  wire logic [1:0] line_state,   // 0 between, 1 positive, 2 negative
  input  wire logic       indicator_o,  // Drain data from the device
  input  wire logic       indicator_oe, // Device pulls the pin
  output logic            ring_sense_a, // Above positive threshold
  output logic            ring_sense_b, // Below negative threshold
  output logic            indicator_pin // Resolved pin level
);
  // Comparators exclusive: one line voltage cannot be both
  assign ring_sense_a = (line_state == 2'h1);
  assign ring_sense_b = (line_state == 2'h2);
  // Pull-up wins whenever the drain is released
  assign indicator_pin = indicator_oe ? indicator_o : 1'b1;
endmodule

// File: bench/test_ring_detect_validate.sv
// Self-checking bench for the ring detector
`timescale 1ns/100ps
`include "rdv_defines.svh"
module test_ring_detect_validate;
  import rdv_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sense_a, sense_b, ind_o, ind_oe;
  logic        indicator_pin, analog_out_irq_pin, transmit_sample_valid, sleep_mode, pcm_ok;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, threshold_sel, line_state;
  logic [15:0] transmit_sample_out;
  int          fail_count, n_tests;
  localparam logic [15:0] TX_EXP [6] = '{16'h8000, 16'h7FFF, 16'h8000, 16'h04CC, 16'h7FFF, 16'h8000};

  // Short counts keep the one-shot at 200 cycles
  rdv_top #(.TICK_CYC(10), .SAMPLE_CYC(5), .ONESHOT_MS(20)) rdv_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ring_sense_a(sense_a),
    .ring_sense_b(sense_b), .sleep_mode(sleep_mode), .pcm_clock_ok(pcm_ok), .threshold_sel(threshold_sel),
    .ring_indicator_pin_o(ind_o), .ring_indicator_pin_oe(ind_oe),
    .analog_out_irq_pin(analog_out_irq_pin), .transmit_sample_out(transmit_sample_out),
    .transmit_sample_valid(transmit_sample_valid));

  rdv_line_model rdv_line_model_inst (
    .line_state(line_state), .indicator_o(ind_o), .indicator_oe(ind_oe),
    .ring_sense_a(sense_a), .ring_sense_b(sense_b), .indicator_pin(indicator_pin));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    conclude();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ends on a falling edge so registered outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic drive_line(input logic [1:0] v);
    @(posedge aclk);
    line_state <= v;
  endtask

  // Handshake is judged at the falling edge before the taking edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic aw, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (i == 50) timeout();
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ar, v;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
      if (v) break;
    end
    rready <= 1'b0;
    if (i == 50) timeout();
  endtask

  task automatic set_ctrl(input rdv_ctrl_type c);
    logic [1:0] r;
    axi_write(`RDV_CTRL_OFS, {21'h0, c}, r);
  endtask

  // Status flags only; the interrupt flag bit is masked off
  task automatic get_stat(output logic [31:0] s);
    logic [1:0] r;
    axi_read(`RDV_STAT_OFS, s, r);
    s = s & 32'h7;
  endtask

  task automatic sample_is(input logic [15:0] exp);
    int i, n;
    n = 0;
    for (i = 0; i < 40 && n < 2; i++) begin
      @(negedge aclk);
      if (transmit_sample_valid === 1'b1) n++;
    end
    if (n < 2) timeout();
    chk("tx sample", {16'h0, exp}, {16'h0, transmit_sample_out});
  endtask

  task automatic t_reset_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk("indicator idle", 32'h1, indicator_pin);
    chk("irq pin idle", 32'h1, analog_out_irq_pin);
    axi_read(`RDV_CTRL_OFS, d, r);
    chk("ctrl reset", 32'h0, d);
    axi_read(`RDV_VALID_OFS, d, r);
    chk("valid reset", 32'h000A22A8, d);
    axi_read(4'hC, d, r);
    chk("unmapped read resp", `RDV_RESP_ERR, r);
    axi_write(4'hC, 32'hFFFFFFFF, r);
    chk("unmapped write resp", `RDV_RESP_ERR, r);
  endtask

  task automatic t_threshold();
    rdv_ctrl_type c;
    c = '0;
    c.threshold_sel_lo = 1'b1;
    c.threshold_sel_hi = 1'b1;
    set_ctrl(c);
    cyc(2);
    chk("threshold both", 32'h3, threshold_sel);
    c.threshold_sel_lo = 1'b0;
    set_ctrl(c);
    cyc(2);
    chk("threshold hi", 32'h2, threshold_sel);
  endtask

  task automatic t_half_wave();
    rdv_ctrl_type c;
    logic [31:0] s;
    c = '0;
    set_ctrl(c);
    drive_line(2'h2);
    cyc(8);
    chk("pin negative hw", 32'h1, indicator_pin);
    get_stat(s);
    chk("status negative hw", 32'h2, s);
    drive_line(2'h1);
    cyc(8);
    chk("pin positive hw", 32'h0, indicator_pin);
    get_stat(s);
    chk("status positive hw", 32'h5, s);
    drive_line(2'h0);
    cyc(120);
    get_stat(s);
    chk("one-shot held", 32'h4, s);
    cyc(120);
    get_stat(s);
    chk("one-shot expired", 32'h0, s);
    drive_line(2'h1);
    cyc(8);
    drive_line(2'h0);
    c.off_hook = 1'b1;
    set_ctrl(c);
    get_stat(s);
    chk("off hook clears", 32'h0, s);
  endtask

  // Active-high pin: pulled up means asserted
  task automatic t_full_wave();
    rdv_ctrl_type c;
    logic [31:0] s;
    c = '0;
    c.full_wave_sel = 1'b1;
    c.ring_out_polarity = 1'b1;
    set_ctrl(c);
    cyc(4);
    chk("pin idle high pol", 32'h0, indicator_pin);
    drive_line(2'h2);
    cyc(8);
    chk("pin negative fw", 32'h1, indicator_pin);
    get_stat(s);
    chk("status negative fw", 32'h6, s);
    drive_line(2'h0);
    cyc(8);
    chk("pin between fw", 32'h0, indicator_pin);
    c.off_hook = 1'b1;
    set_ctrl(c);
  endtask

  task automatic t_samples();
    rdv_ctrl_type c;
    for (int k = 0; k < 6; k++) begin
      c = '0;
      c.full_wave_sel = (k >= 3);
      set_ctrl(c);
      drive_line(2'(k % 3));
      sample_is(TX_EXP[k]);
    end
    drive_line(2'h1);
    for (int m = 0; m < 3; m++) begin
      c = '0;
      c.off_hook = (m == 0);
      c.onhook_monitor = (m == 1);
      c.isolation_link_powerdown = (m == 2);
      set_ctrl(c);
      sample_is(16'h0000);
    end
    drive_line(2'h0);
  endtask

  // Rising-only edge select leaves the ring end silent; second pass uses an active-high pin
  task automatic t_irq();
    rdv_ctrl_type c;
    logic [1:0] r;
    for (int e = 0; e < 2; e++) begin
      c = '0;
      c.ring_irq_mask = 1'b1;
      c.both_edge_irq_sel = e[0];
      c.irq_active_high = e[0];
      set_ctrl(c);
      axi_write(`RDV_STAT_OFS, 32'h8, r);
      drive_line(2'h1);
      cyc(8);
      drive_line(2'h0);
      cyc(8);
      chk("irq on ring", {31'h0, e[0]}, analog_out_irq_pin);
      axi_write(`RDV_STAT_OFS, 32'h8, r);
      cyc(3);
      chk("irq cleared", {31'h0, ~e[0]}, analog_out_irq_pin);
      cyc(260);
      chk("irq at ring end", 32'h1, analog_out_irq_pin);
    end
  endtask

  // One lone crossing must not pass validation
  task automatic t_validation();
    rdv_ctrl_type c;
    logic [31:0] s;
    c = '0;
    c.validation_enable = 1'b1;
    set_ctrl(c);
    drive_line(2'h1);
    cyc(8);
    chk("pin unvalidated", 32'h1, indicator_pin);
    get_stat(s);
    chk("status unvalidated", 32'h1, s);
    @(posedge aclk);
    sleep_mode <= 1'b1;
    pcm_ok <= 1'b0;
    cyc(6);
    get_stat(s);
    chk("status sleep no clock", 32'h5, s);
    @(posedge aclk);
    pcm_ok <= 1'b1;
    cyc(6);
    get_stat(s);
    chk("status sleep clock", 32'h1, s);
    drive_line(2'h0);
  endtask

  // Alternating crossings 15 ticks apart: envelope after the delay, gone after ring end
  task automatic t_valid_ring();
    rdv_ctrl_type c;
    logic [31:0] s;
    c = '0;
    c.validation_enable = 1'b1;
    set_ctrl(c);
    for (int p = 0; p < 10; p++) begin
      drive_line(2'h1);
      cyc(150);
      drive_line(2'h2);
      cyc(150);
      if (p == 2) begin
        get_stat(s);
        chk("envelope waits", 32'h2, s);
      end
    end
    get_stat(s);
    chk("envelope up", 32'h6, s);
    chk("pin envelope", 32'h0, indicator_pin);
    drive_line(2'h0);
    cyc(5400);
    get_stat(s);
    chk("envelope ended", 32'h0, s);
  endtask

  // Inputs at rest, reset held for 12 cycles
  initial begin
    fail_count = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    line_state = 2'h0;
    sleep_mode = 1'b0;
    pcm_ok = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(3);
    t_reset_regs();
    t_threshold();
    t_half_wave();
    t_full_wave();
    t_samples();
    t_irq();
    t_validation();
    t_valid_ring();
    conclude();
  end
endmodule
